// ===== src/amp_gain_pkg.sv
// Shared constants and types for the cable amplifier gain writer.
package amp_gain_pkg;

	// Register offsets on the register port.
	localparam logic [7:0] OFS_CHIP_CTRL = 8'h00;
	localparam logic [7:0] OFS_GAIN_MODE = 8'h0f;
	localparam logic [7:0] OFS_GAIN_P0   = 8'h13;
	localparam logic [7:0] OFS_GAIN_P1   = 8'h17;
	localparam logic [7:0] OFS_GAIN_P2   = 8'h1b;
	localparam logic [7:0] OFS_GAIN_P3   = 8'h1f;

	// Field positions inside the control registers.
	localparam int SOFT_RST_BIT  = 5;
	localparam int PROF_SEL_LSB  = 0;
	localparam int BUSY_BIT      = 7;
	localparam int GAIN_MODE_BIT = 0;

	// Values after reset.
	localparam logic [7:0] GAIN_RESET     = 8'h00;
	localparam logic [1:0] PROF_SEL_RESET = 2'h0;
	localparam logic       MODE_RESET     = 1'b0;

	// Cycle counts at the master clock.
	localparam int SETTLE_MIN_CYC = 48;
	localparam int SETTLE_MAX_CYC = 64;
	localparam int SETTLE_CYC     = (SETTLE_MIN_CYC + SETTLE_MAX_CYC) / 2;
	localparam int XFER_MAX_CYC   = 200;
	localparam int SCLK_HALF_CYC  = 6;
	localparam int GAIN_BITS      = 8;
	localparam int FRAME_TICKS    = 2 * GAIN_BITS + 2;
	localparam int FRAME_LOW_CYC  = FRAME_TICKS * SCLK_HALF_CYC;

	// The three wires toward the amplifier travel together.
	typedef struct packed {
		logic amp_write_frame_n;
		logic sclk;
		logic sdata;
	} amp_link_t;

	localparam amp_link_t LINK_IDLE = '{amp_write_frame_n: 1'b1, sclk: 1'b0, sdata: 1'b0};

	// Transfer sequencer states.
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_SETTLE = 3'b001,
		ST_FRAME  = 3'b010,
		ST_SHIFT  = 3'b011,
		ST_TAIL   = 3'b100
	} xfer_state_t;

endpackage

// ===== src/amp_half_timer.sv
// Restartable divider giving one enable pulse per serial half period.
`timescale 1ns/1ps
module amp_half_timer
	import amp_gain_pkg::*;
#(
	parameter int HALF = SCLK_HALF_CYC
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst,
	// Restart the count so the first pulse lands a full half period later.
	input  wire logic restart,
	// One-cycle enable pulse.
	output logic      tick
);

	localparam int CW = $clog2(HALF + 1);

	logic [CW-1:0] cnt_reg;  // Cycles elapsed in this half period.
	wire           wrap_w = (cnt_reg == CW'(HALF - 1));  // Last cycle of the half.

	assign tick = wrap_w && !restart;

	// Count up and wrap; a restart always wins so the timing is aligned to the frame.
	always_ff @(posedge clk) begin
		if (rst || restart || wrap_w) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + CW'(1);
		end
	end

endmodule // amp_half_timer

// ===== src/cable_amp_gain_writer.sv
// Gain register file and 3-wire writer for an external cable driver amplifier.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
// What this block does
// - Four 8-bit gain registers, one per profile.
// - Mode bit at 0x0F reshapes the gain words.
// - Hardware reset clears gains, sends zero word.
// - Writing one to bit 5 of 0x00 resets.
// - Soft reset clears gains and profile select.
// - Soft reset sends zero only if gain nonzero.
// - Profile pin plus select bits change triggers write.
// - Sent word comes from selected profile register.
// - Changing selected gain register sends new word.
// - Wait 48 to 64 cycles, then frame low.
// - A started serial write always completes.
// - Whole transfer within 200 cycles, no spurious writes.
// - Gain goes out over dedicated 3-wire port.
module cable_amp_gain_writer
	import amp_gain_pkg::*;
(
	// Clock and synchronous reset.
	input  wire logic       CLK,
	input  wire logic       SYS_RST,
	// Register port.
	input  wire logic [7:0] REG_ADDR,
	input  wire logic [7:0] REG_WDATA,
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	output logic      [7:0] REG_RDATA,
	// Asynchronous profile pin.
	input  wire logic       PROFILE_PIN,
	// Three wires toward the amplifier.
	output amp_link_t       AMP_LINK
);

	// Mode 1 drives an amplifier with a six-bit gain field, so the top bits are held at zero.
	function automatic logic [7:0] shape_gain(input logic mode, input logic [7:0] g);
		shape_gain = mode ? {2'b00, g[5:0]} : g;
	endfunction

	// Gain registers sit at every fourth offset from 0x13.
	function automatic logic is_gain_addr(input logic [7:0] a);
		is_gain_addr = (a[7:4] == 4'h1) && (a[1:0] == 2'b11);
	endfunction

	logic [7:0]  gain_reg [4];     // Per-profile gain storage.
	logic [1:0]  prof_sel_reg;     // Software profile select bits.
	logic        mode_reg;         // Gain interpretation select.
	logic        pin_meta_reg;     // First synchroniser stage of the profile pin.
	logic        pin_sync_reg;     // Second synchroniser stage.
	xfer_state_t state_reg;        // Sequencer state.
	xfer_state_t state_next;
	logic [5:0]  settle_cnt_reg;   // Cycles the candidate word has been stable.
	logic [5:0]  settle_cnt_next;
	logic [7:0]  held_reg;         // Candidate word, then the word being sent.
	logic [7:0]  held_next;
	logic [7:0]  shift_reg;        // Serial shifter, MSB leaves first.
	logic [7:0]  shift_next;
	logic [7:0]  shadow_reg;       // Word the amplifier currently holds.
	logic [7:0]  shadow_next;
	logic        init_pending_reg; // Forces one send after hardware reset.
	logic        init_pending_next;
	logic [2:0]  bit_cnt_reg;      // Bit being shifted.
	logic [2:0]  bit_cnt_next;
	amp_link_t   link_reg;         // Registered amplifier wires.
	amp_link_t   link_next;
	logic [7:0]  rdata_reg;        // Registered read data.
	logic        timer_restart;    // Aligns the half-period timer to the frame.
	wire         tick_w;           // One pulse per serial half period.

	// Register port decode.
	wire       wr_ctrl_w   = REG_WR && (REG_ADDR == OFS_CHIP_CTRL);
	wire       soft_rst_w  = wr_ctrl_w && REG_WDATA[SOFT_RST_BIT];
	wire       wr_mode_w   = REG_WR && (REG_ADDR == OFS_GAIN_MODE);
	wire       wr_gain_w   = REG_WR && is_gain_addr(REG_ADDR);
	wire [1:0] wr_idx_w    = REG_ADDR[3:2];
	wire       busy_w      = (state_reg != ST_IDLE);

	// Selected profile and the word it asks for.
	wire [1:0] prof_idx_w  = prof_sel_reg ^ {1'b0, pin_sync_reg};
	wire [7:0] desired_w   = shape_gain(mode_reg, gain_reg[prof_idx_w]);
	wire       need_send_w = init_pending_reg || (desired_w != shadow_reg);

	// Read data selection; unmapped offsets read as zero.
	wire [7:0] ctrl_rd_w   = {busy_w, 5'h00, prof_sel_reg};
	wire [7:0] rd_value_w  = (REG_ADDR == OFS_CHIP_CTRL) ? ctrl_rd_w :
	                         (REG_ADDR == OFS_GAIN_MODE) ? {7'h00, mode_reg} :
	                         is_gain_addr(REG_ADDR)      ? gain_reg[REG_ADDR[3:2]] : 8'h00;

	amp_half_timer #(
		.HALF(SCLK_HALF_CYC)
	) u_half_timer (
		.clk     (CLK),
		.rst     (SYS_RST),
		.restart (timer_restart),
		.tick    (tick_w)
	);

	// The profile pin is asynchronous, so two flops stand before any logic reads it.
	always_ff @(posedge CLK) begin
		pin_meta_reg <= PROFILE_PIN;
		pin_sync_reg <= pin_meta_reg;
	end

	// Gain storage; both resets clear it to the lowest amplifier gain.
	always_ff @(posedge CLK) begin
		for (int i = 0; i < 4; i++) begin
			if (SYS_RST || soft_rst_w) begin
				gain_reg[i] <= GAIN_RESET;
			end else if (wr_gain_w && (wr_idx_w == 2'(i))) begin
				gain_reg[i] <= REG_WDATA;
			end
		end
	end

	// Control bits; a soft reset overrides any select bits written with it.
	always_ff @(posedge CLK) begin
		if (SYS_RST || soft_rst_w) begin
			prof_sel_reg <= PROF_SEL_RESET;
		end else if (wr_ctrl_w) begin
			prof_sel_reg <= REG_WDATA[PROF_SEL_LSB +: 2];
		end
		if (SYS_RST) begin
			mode_reg <= MODE_RESET;
		end else if (wr_mode_w) begin
			mode_reg <= REG_WDATA[GAIN_MODE_BIT];
		end
	end

	// Read data stands in the cycle after the strobe only.
	always_ff @(posedge CLK) begin
		if (SYS_RST || !REG_RD) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rd_value_w;
		end
	end

	// Sequencer next-state logic.
	always_comb begin
		state_next        = state_reg;
		settle_cnt_next   = settle_cnt_reg;
		held_next         = held_reg;
		shift_next        = shift_reg;
		shadow_next       = shadow_reg;
		init_pending_next = init_pending_reg;
		bit_cnt_next      = bit_cnt_reg;
		link_next         = link_reg;
		timer_restart     = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				// Any difference from what the amplifier holds opens a settle window.
				if (need_send_w) begin
					state_next      = ST_SETTLE;
					settle_cnt_next = '0;
					held_next       = desired_w;
				end
			end
			ST_SETTLE: begin
				if (!need_send_w) begin
					// Value went back to what was sent; writing it again would be spurious.
					state_next = ST_IDLE;
				end else if (desired_w != held_reg) begin
					// Still moving; restart the stability count.
					held_next       = desired_w;
					settle_cnt_next = '0;
				end else if (settle_cnt_reg == 6'(SETTLE_CYC - 1)) begin
					state_next    = ST_FRAME;
					shift_next    = held_reg;
					link_next     = '{amp_write_frame_n: 1'b0, sclk: 1'b0, sdata: held_reg[7]};
					bit_cnt_next  = '0;
					timer_restart = 1'b1;
				end else begin
					settle_cnt_next = settle_cnt_reg + 6'(1);
				end
			end
			ST_FRAME: begin
				// Data has had a half period of setup; raise the first clock.
				if (tick_w) begin
					state_next     = ST_SHIFT;
					link_next.sclk = 1'b1;
				end
			end
			ST_SHIFT: begin
				// No event is looked at here: once begun, the word always completes.
				if (tick_w && link_reg.sclk) begin
					link_next.sclk = 1'b0;
					// The bit counter wraps to zero after the last bit and then paces the tail.
					bit_cnt_next   = bit_cnt_reg + 3'(1);
					if (bit_cnt_reg == 3'(GAIN_BITS - 1)) begin
						state_next = ST_TAIL;
					end else begin
						shift_next      = {shift_reg[6:0], 1'b0};
						link_next.sdata = shift_reg[6];
					end
				end else if (tick_w) begin
					link_next.sclk = 1'b1;
				end
			end
			ST_TAIL: begin
				// The last bit keeps its low half, then one more half of hold before release,
				// so the amplifier never sees the frame rise right on a serial clock edge.
				if (tick_w && bit_cnt_reg == 3'h0) begin
					bit_cnt_next = 3'h1;
				end else if (tick_w) begin
					// Releasing the frame latches the word inside the amplifier.
					state_next        = ST_IDLE;
					link_next         = LINK_IDLE;
					shadow_next       = held_reg;
					init_pending_next = 1'b0;
				end
			end
			default: begin
				state_next = ST_IDLE;
				link_next  = LINK_IDLE;
			end
		endcase
	end

	// Sequencer registers; hardware reset arms one all-zero send.
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			state_reg        <= ST_IDLE;
			settle_cnt_reg   <= '0;
			held_reg         <= GAIN_RESET;
			shift_reg        <= GAIN_RESET;
			shadow_reg       <= GAIN_RESET;
			init_pending_reg <= 1'b1;
			bit_cnt_reg      <= '0;
			link_reg         <= LINK_IDLE;
		end else begin
			state_reg        <= state_next;
			settle_cnt_reg   <= settle_cnt_next;
			held_reg         <= held_next;
			shift_reg        <= shift_next;
			shadow_reg       <= shadow_next;
			init_pending_reg <= init_pending_next;
			bit_cnt_reg      <= bit_cnt_next;
			link_reg         <= link_next;
		end
	end

	assign REG_RDATA = rdata_reg;
	assign AMP_LINK  = link_reg;

	// Helper counters watched only by the checks below.
	logic [7:0] low_cnt_reg;   // Cycles the frame has been low.
	logic [4:0] rise_cnt_reg;  // Serial clock rises inside the frame.
	logic [8:0] busy_cnt_reg;  // Cycles since the sequencer left idle.
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			low_cnt_reg  <= '0;
			rise_cnt_reg <= '0;
			busy_cnt_reg <= '0;
		end else begin
			low_cnt_reg  <= link_reg.amp_write_frame_n ? 8'h00 : low_cnt_reg + 8'h01;
			rise_cnt_reg <= link_reg.amp_write_frame_n ? 5'h00 :
			                rise_cnt_reg + 5'(link_next.sclk && !link_reg.sclk);
			busy_cnt_reg <= busy_w ? busy_cnt_reg + 9'h001 : 9'h000;
		end
	end

	localparam int LOW_LAST  = FRAME_LOW_CYC;
	localparam int BUSY_MAX  = XFER_MAX_CYC;

	a_reset_arms_send: assert property (@(posedge CLK)
		$past(SYS_RST) && !SYS_RST |-> init_pending_reg && desired_w == 8'h00 && state_reg == ST_IDLE)
		else $error("hardware reset did not arm a zero-word send");

	a_soft_reset_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
		soft_rst_w |=> prof_sel_reg == 2'h0 && gain_reg[0] == 8'h00 && gain_reg[3] == 8'h00)
		else $error("soft reset did not clear gains and profile select");

	a_mode_shapes_word: assert property (@(posedge CLK) disable iff (SYS_RST)
		mode_reg |-> desired_w[7:6] == 2'b00)
		else $error("gain mode did not reshape the word");

	a_change_starts_settle: assert property (@(posedge CLK) disable iff (SYS_RST)
		state_reg == ST_IDLE && desired_w != shadow_reg |=> state_reg == ST_SETTLE)
		else $error("changed gain did not start a transfer");

	a_no_spurious_send: assert property (@(posedge CLK) disable iff (SYS_RST)
		state_reg == ST_IDLE && !need_send_w |=> state_reg == ST_IDLE)
		else $error("transfer started without a changed word");

	a_settle_window: assert property (@(posedge CLK) disable iff (SYS_RST)
		$fell(link_reg.amp_write_frame_n) |->
			$past(settle_cnt_reg) == 6'(SETTLE_CYC - 1) && $past(state_reg) == ST_SETTLE)
		else $error("frame fell without a full settle window");

	a_word_from_profile: assert property (@(posedge CLK) disable iff (SYS_RST)
		$fell(link_reg.amp_write_frame_n) |->
			shift_reg == $past(desired_w) && link_reg.sdata == shift_reg[7])
		else $error("sent word is not the selected profile gain");

	a_frame_completes: assert property (@(posedge CLK) disable iff (SYS_RST)
		$rose(link_reg.amp_write_frame_n) |->
			$past(low_cnt_reg) == 8'(LOW_LAST - 1) && $past(rise_cnt_reg) == 5'(GAIN_BITS))
		else $error("serial frame cut short or wrong bit count");

	a_frame_stays_low: assert property (@(posedge CLK) disable iff (SYS_RST)
		$fell(link_reg.amp_write_frame_n) |=> !link_reg.amp_write_frame_n [*8])
		else $error("frame released early");

	a_xfer_bound: assert property (@(posedge CLK) disable iff (SYS_RST)
		busy_cnt_reg <= 9'(BUSY_MAX))
		else $error("transfer exceeded its cycle budget");

	c_reset_send:  cover property (@(posedge CLK) disable iff (SYS_RST)
		init_pending_reg && $rose(link_reg.amp_write_frame_n));
	c_soft_during: cover property (@(posedge CLK) disable iff (SYS_RST)
		soft_rst_w && state_reg == ST_SHIFT);
	c_pin_change:  cover property (@(posedge CLK) disable iff (SYS_RST)
		$changed(pin_sync_reg) && state_reg == ST_IDLE ##1 state_reg == ST_SETTLE);
	// A gain write that lands while a word is on the wire must wait for the next frame.
	c_write_in_frame: cover property (@(posedge CLK) disable iff (SYS_RST)
		wr_gain_w && state_reg == ST_SHIFT);

endmodule // cable_amp_gain_writer

// ===== testbench/amp_gain_amp_model.sv
// Behavioural model of the serial gain input of the cable amplifier.
`timescale 1ns/1ps
module amp_gain_amp_model
	import amp_gain_pkg::*;
(
	// Master clock used to sample the link.
	input  wire logic       clk,
	// Three wires from the writer.
	input  amp_link_t       link,
	// What the amplifier has latched.
	output int              frames,
	output logic      [7:0] word,
	output int              bits,
	output int              low_len
);
	logic       prev_sclk = 1'b0;  // Serial clock one sample ago.
	logic       prev_fn   = 1'b1;  // Frame line one sample ago.
	logic [7:0] shreg     = 8'h00; // Bits gathered in this frame.
	int         bit_cnt   = 0;     // Rising serial clocks seen in this frame.
	int         low_cnt   = 0;     // Samples with the frame line low.

	initial begin
		frames = 0;
		word = 8'h00;
		bits = 0;
		low_len = 0;
	end

	// The amplifier takes a bit on each rising serial clock and latches the word when the
	// frame line returns high; a frame of the wrong length still latches, so the bench sees it.
	always @(posedge clk) begin
		prev_sclk <= link.sclk;
		prev_fn <= link.amp_write_frame_n;
		if (link.amp_write_frame_n === 1'b0) begin
			low_cnt <= low_cnt + 1;
			if (link.sclk === 1'b1 && prev_sclk === 1'b0) begin
				shreg <= {shreg[6:0], link.sdata};
				bit_cnt <= bit_cnt + 1;
			end
		end
		if (link.amp_write_frame_n === 1'b1 && prev_fn === 1'b0) begin
			word <= shreg;
			bits <= bit_cnt;
			low_len <= low_cnt;
			frames <= frames + 1;
			low_cnt <= 0;
			bit_cnt <= 0;
		end
	end
endmodule // amp_gain_amp_model

// ===== testbench/cable_amp_gain_writer_bench.sv
// Self-checking bench for the cable amplifier gain writer.
`timescale 1ns/1ps
module cable_amp_gain_writer_bench
	import amp_gain_pkg::*;
();
	logic       CLK         = 1'b0;  // Master clock.
	logic       SYS_RST     = 1'b1;  // Synchronous reset.
	logic [7:0] REG_ADDR    = 8'h00; // Register port.
	logic [7:0] REG_WDATA   = 8'h00;
	logic       REG_WR      = 1'b0;
	logic       REG_RD      = 1'b0;
	logic [7:0] REG_RDATA;
	logic       PROFILE_PIN = 1'b0;  // Profile pin.
	amp_link_t  AMP_LINK;
	int         fail_count  = 0;     // Mismatches seen.
	int         compares    = 0;     // Comparisons made.
	int         cycles      = 0;     // Clock cycles since start.
	int         frames, bits, low_len;
	logic [7:0] word, rd, g;
	logic [7:0] gains [4] = '{default: 8'h00}; // Expected gain registers.
	logic [1:0] sel       = 2'h0;              // Expected profile select bits.
	logic       mode      = 1'b0;              // Expected gain mode bit.
	localparam logic [7:0] GAIN_OFS [4] = '{OFS_GAIN_P0, OFS_GAIN_P1, OFS_GAIN_P2, OFS_GAIN_P3};

	cable_amp_gain_writer dut (.CLK(CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.PROFILE_PIN(PROFILE_PIN), .AMP_LINK(AMP_LINK));
	amp_gain_amp_model amp (.clk(CLK), .link(AMP_LINK), .frames(frames), .word(word),
		.bits(bits), .low_len(low_len));

	// Clock at 200 MHz.
	initial forever #2.5 CLK = ~CLK;

	// Counts and reports one comparison.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One-cycle write strobe.
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CLK);
		REG_WR <= 1'b0;
	endtask

	// One-cycle read strobe; the data stand only in the following cycle.
	task automatic reg_read(input logic [7:0] a);
		@(posedge CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CLK);
		REG_RD <= 1'b0;
		#1;
		rd = REG_RDATA;
	endtask

	// Word the amplifier should hold for the present settings.
	function automatic logic [7:0] exp_word();
		logic [7:0] w;
		w = gains[sel ^ {1'b0, PROFILE_PIN}];
		if (mode)
			w[7:6] = 2'h0;
		return w;
	endfunction

	// Waits for one frame and checks its timing and content; optionally writes the selected
	// gain while the frame is running, which must not disturb it.
	task automatic wait_frame(input logic [7:0] exp, input bit mid, input logic [7:0] late);
		int n;
		int f0;
		n = 0;
		f0 = frames;
		while (AMP_LINK.amp_write_frame_n === 1'b1 && n < 300) begin
			@(posedge CLK);
			#1;
			n++;
		end
		check(32'(n >= SETTLE_MIN_CYC), 32'h1);
		if (mid)
			reg_write(GAIN_OFS[sel ^ {1'b0, PROFILE_PIN}], late);
		while (frames == f0 && n < 300) begin
			@(posedge CLK);
			#1;
			n++;
		end
		check(32'(n <= XFER_MAX_CYC), 32'h1);
		check(word, exp);
		check(bits, GAIN_BITS);
		check(low_len, FRAME_LOW_CYC);
	endtask

	// No frame may complete within a full transfer time.
	task automatic expect_none();
		int f0;
		f0 = frames;
		repeat (XFER_MAX_CYC) @(posedge CLK);
		check(frames, f0);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop();
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// A hang is cut short well beyond the expected run of about three thousand cycles.
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			report_and_stop();
		end
	end

	// Main sequence.
	initial begin
		void'($urandom(32'h3b5223f1));
		repeat (20) @(posedge CLK);
		SYS_RST <= 1'b0;
		wait_frame(8'h00, 1'b0, 8'h00);
		$display("test reset_word done");
		// Unselected profiles read zero, then take values without any frame.
		for (int p = 1; p < 4; p++) begin
			reg_read(GAIN_OFS[p]);
			check(rd, GAIN_RESET);
			gains[p] = {2'(p), 6'($urandom)};
			reg_write(GAIN_OFS[p], gains[p]);
		end
		expect_none();
		reg_read(8'h05);
		check(rd, 8'h00);
		for (int p = 0; p < 4; p++) begin
			reg_read(GAIN_OFS[p]);
			check(rd, gains[p]);
		end
		gains[0] = {2'h0, 6'($urandom)} | 8'h01;
		reg_write(OFS_GAIN_P0, gains[0]);
		wait_frame(exp_word(), 1'b0, 8'h00);
		$display("test gain_registers done");
		// Every nonzero select value, then the pin flipping the low select bit.
		for (int s = 1; s < 4; s++) begin
			sel = 2'(s);
			reg_write(OFS_CHIP_CTRL, {6'h00, sel});
			wait_frame(exp_word(), 1'b0, 8'h00);
			reg_read(OFS_CHIP_CTRL);
			check(rd[1:0], sel);
		end
		@(posedge CLK);
		PROFILE_PIN <= 1'b1;
		#1;
		wait_frame(exp_word(), 1'b0, 8'h00);
		$display("test profile_select done");
		mode = 1'b1;
		reg_write(OFS_GAIN_MODE, 8'h01);
		wait_frame(exp_word(), 1'b0, 8'h00);
		$display("test gain_mode done");
		// A write in mid-frame waits for the running frame, then goes out in its own frame.
		for (int i = 0; i < 3; i++) begin
			gains[2] += 8'(1 + $urandom % 62);
			reg_write(OFS_GAIN_P2, gains[2]);
			g = exp_word();
			gains[2] += 8'h01;
			wait_frame(g, 1'b1, gains[2]);
			wait_frame(exp_word(), 1'b0, 8'h00);
		end
		$display("test frame_no_abort done");
		// Soft reset with select bits in the same write; the reset wins.
		sel = 2'h0;
		gains = '{default: 8'h00};
		reg_write(OFS_CHIP_CTRL, 8'h23);
		wait_frame(8'h00, 1'b0, 8'h00);
		reg_read(OFS_CHIP_CTRL);
		check(rd[1:0], 2'h0);
		reg_read(OFS_GAIN_P2);
		check(rd, 8'h00);
		reg_write(OFS_CHIP_CTRL, 8'h20);
		expect_none();
		$display("test soft_reset done");
		report_and_stop();
	end
endmodule // cable_amp_gain_writer_bench
